/* File: shared/scpc_pkg.sv */
package scpc_pkg;
  // Timing and sizes
  localparam int CLK_MHZ       = 125;
  localparam int PLL_SETTLE_US = 100;
  localparam int PLL_LOCK_CYC  = PLL_SETTLE_US * CLK_MHZ;
  localparam int WAKE_CYC      = 1024;
  localparam int FILT_CYC      = 4;
  localparam int NPERIPH       = 8;
  localparam int ADDR_W        = 12;
  // Loop oscillator accumulator
  localparam int MSEL_W        = 5;
  localparam int PSEL_W        = 2;
  localparam logic [5:0] LOOP_MOD = 6'h20;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_PLL_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PLL_CFG   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PLL_STAT  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_PWR_MODE  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_PERIPH    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PCLK_DIV  = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_MEM_MAP   = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_EXT_WAKE  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_RST_STAT  = 12'h020;
  // Field positions
  localparam int PLL_EN_BIT    = 0;
  localparam int PLL_CONN_BIT  = 1;
  localparam int CFG_MSEL_LSB  = 0;
  localparam int CFG_PSEL_LSB  = 5;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_CONN_BIT = 2;
  localparam int PWR_IDLE_BIT  = 0;
  localparam int PWR_PD_BIT    = 1;
  localparam int RST_PIN_BIT   = 0;
  localparam int RST_WDT_BIT   = 1;
  // Reset values and encodings
  localparam logic [1:0] PDIV_DIV4 = 2'h0;
  localparam logic [1:0] PDIV_DIV1 = 2'h1;
  localparam logic [1:0] PDIV_DIV2 = 2'h2;
  localparam logic [1:0] PDIV_RST  = PDIV_DIV4;
  localparam logic       MAP_RST   = 1'b0;
  localparam logic [MSEL_W-1:0] MSEL_RST = 5'h00;
  localparam logic [PSEL_W-1:0] PSEL_RST = 2'h0;
  localparam logic [2:0]        WAKE_EN_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAKE,
    ST_RUN,
    ST_IDLE,
    ST_PDOWN
  } scpc_state_e;
endpackage

/* File: rtl/scpc_top.sv */
`timescale 1ns/1ns
module scpc_top #(
  parameter int LOCK_CYCLES = scpc_pkg::PLL_LOCK_CYC,
  parameter int WAKE_CYCLES = scpc_pkg::WAKE_CYC,
  parameter int FILT_CYCLES = scpc_pkg::FILT_CYC,
  parameter int NPERIPH     = scpc_pkg::NPERIPH
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [scpc_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  output logic      [31:0]                 prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  input  wire logic                        rst_pin_n_in,
  input  wire logic                        wdt_rst_in,
  input  wire logic                        osc_running_in,
  input  wire logic                        flash_init_done_in,
  input  wire logic [2:0]                  ext_int_in,
  input  wire logic                        irq_in,
  output logic                             osc_en_out,
  output logic                             pll_clk_out,
  output logic                             pll_lock_out,
  output logic                             cpu_clk_en_out,
  output logic                             pclk_en_out,
  output logic                             chip_rst_out,
  output logic                             cpu_start_out,
  output logic                             remap_sram_out,
  output logic      [NPERIPH-1:0]          periph_pwr_out,
  output logic                             pin_hold_out
);
  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam int WW = $clog2(WAKE_CYCLES + 1);
  localparam int FW = $clog2(FILT_CYCLES + 1);

  // Sync order: {osc, ext[2:0], rst_n}
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {osc_running_in, ext_int_in, rst_pin_n_in};
      sync2 <= sync1;
    end
  end
  logic       osc_s;
  logic [2:0] ext_s;
  assign osc_s = sync2[4];
  assign ext_s = sync2[3:1];

  // Glitch filter: level must hold FILT_CYCLES before it counts
  logic          pin_rst;
  logic          next_pin_rst;
  logic [FW-1:0] filt_cnt;
  logic [FW-1:0] next_filt_cnt;
  always_comb begin
    next_pin_rst  = pin_rst;
    next_filt_cnt = '0;
    if (~sync2[0] != pin_rst) begin
      next_filt_cnt = filt_cnt + 1'b1;
      if (filt_cnt == FW'(FILT_CYCLES - 1)) begin
        next_pin_rst  = ~pin_rst;
        next_filt_cnt = '0;
      end
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pin_rst  <= 1'b1;
      filt_cnt <= '0;
    end else begin
      pin_rst  <= next_pin_rst;
      filt_cnt <= next_filt_cnt;
    end
  end

  logic rst_src;
  assign rst_src = pin_rst | wdt_rst_in;

  // Control and register state
  scpc_pkg::scpc_state_e st;
  scpc_pkg::scpc_state_e next_st;
  logic                          pll_en, next_pll_en;
  logic                          pll_conn, next_pll_conn;
  logic [scpc_pkg::MSEL_W-1:0]   msel, next_msel;
  logic [scpc_pkg::PSEL_W-1:0]   psel, next_psel;
  logic [1:0]                    pdiv, next_pdiv;
  logic                          remap, next_remap;
  logic [2:0]                    wake_en, next_wake_en;
  logic [NPERIPH-1:0]            pper, next_pper;
  logic [1:0]                    rst_stat, next_rst_stat;
  logic                          from_rst, next_from_rst;
  logic [WW-1:0]                 wake_cnt, next_wake_cnt;
  logic                          next_chip_rst;
  logic                          next_cpu_start;
  logic                          next_pready;
  logic [31:0]                   next_prdata;
  logic                          next_pslverr;

  // PLL and clock state
  logic                          pll_lock;
  logic [LW-1:0]                 lock_cnt;
  logic [LW-1:0]                 next_lock_cnt;
  logic                          next_pll_lock;
  logic [4:0]                    pll_acc, next_pll_acc;
  logic [2:0]                    pll_half, next_pll_half;
  logic                          next_pll_clk;
  logic [1:0]                    pdiv_cnt, next_pdiv_cnt;
  logic                          next_cpu_en;
  logic                          next_pclk_en;

  logic        apb_wr;
  logic        apb_rd_phase;
  logic        cfg_wr;
  logic        hit;
  logic [31:0] rd_val;
  logic        wake_done;
  logic        pll_run;
  logic        use_pll;
  logic [5:0]  acc_sum;
  logic        loop_tick;
  logic [2:0]  half_lim;
  logic        pll_rise;
  logic        src_tick;
  logic [1:0]  pdiv_lim;
  logic        clk_live;

  // One wait state: pready registered off the access phase
  assign apb_rd_phase = psel_in & penable_in & ~pready_out;
  assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
  assign cfg_wr = apb_wr & (paddr_in == scpc_pkg::OFS_PLL_CFG);
  assign wake_done = osc_s & (wake_cnt == WW'(WAKE_CYCLES - 1));

  // Idle keeps a running PLL; only power-down stops it
  assign pll_run = pll_en & (st != scpc_pkg::ST_PDOWN);
  // PLL feeds the processor only when running, connected and locked
  assign use_pll = pll_run & pll_conn & pll_lock;

  // Scaled loop model: loop tick rate is input * (msel+1) / 32
  assign acc_sum = {1'b0, pll_acc} + {1'b0, msel} + 6'h01;
  assign loop_tick = pll_run & (acc_sum >= scpc_pkg::LOOP_MOD);

  always_comb begin
    unique case (psel)
      2'h0: half_lim = 3'h0;
      2'h1: half_lim = 3'h1;
      2'h2: half_lim = 3'h3;
      2'h3: half_lim = 3'h7;
    endcase
  end
  assign pll_rise = loop_tick & (pll_half == half_lim) & ~pll_clk_out;
  assign clk_live = (st != scpc_pkg::ST_PDOWN);
  assign src_tick = clk_live & (use_pll ? pll_rise : 1'b1);

  always_comb begin
    unique case (pdiv)
      scpc_pkg::PDIV_DIV1: pdiv_lim = 2'h0;
      scpc_pkg::PDIV_DIV2: pdiv_lim = 2'h1;
      default:             pdiv_lim = 2'h3;
    endcase
  end

  always_comb begin
    next_pll_acc  = pll_acc;
    next_pll_half = pll_half;
    next_pll_clk  = pll_clk_out;
    if (!pll_run) begin
      next_pll_acc  = 5'h00;
      next_pll_half = 3'h0;
      next_pll_clk  = 1'b0;
    end else begin
      next_pll_acc = loop_tick ? 5'(acc_sum - scpc_pkg::LOOP_MOD)
                               : acc_sum[4:0];
      // Equal tick counts per half period give even duty
      if (loop_tick) begin
        if (pll_half == half_lim) begin
          next_pll_half = 3'h0;
          next_pll_clk  = ~pll_clk_out;
        end else begin
          next_pll_half = pll_half + 3'h1;
        end
      end
    end
    // Any reconfiguration forces a fresh settling period
    next_lock_cnt = lock_cnt;
    next_pll_lock = pll_lock;
    if (!pll_run || cfg_wr) begin
      next_lock_cnt = '0;
      next_pll_lock = 1'b0;
    end else if (!pll_lock) begin
      next_lock_cnt = lock_cnt + 1'b1;
      next_pll_lock = (lock_cnt == LW'(LOCK_CYCLES - 1));
    end
    next_pdiv_cnt = pdiv_cnt;
    next_pclk_en  = 1'b0;
    if (st == scpc_pkg::ST_RUN || st == scpc_pkg::ST_IDLE) begin
      if (src_tick) begin
        next_pclk_en  = (pdiv_cnt == 2'h0);
        next_pdiv_cnt = (pdiv_cnt >= pdiv_lim) ? 2'h0 : pdiv_cnt + 2'h1;
      end
    end else begin
      next_pdiv_cnt = 2'h0;
    end
    next_cpu_en = src_tick & (st == scpc_pkg::ST_RUN);
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pll_acc        <= 5'h00;
      pll_half       <= 3'h0;
      pll_clk_out    <= 1'b0;
      lock_cnt       <= '0;
      pll_lock       <= 1'b0;
      pdiv_cnt       <= 2'h0;
      pclk_en_out    <= 1'b0;
      cpu_clk_en_out <= 1'b0;
    end else begin
      pll_acc        <= next_pll_acc;
      pll_half       <= next_pll_half;
      pll_clk_out    <= next_pll_clk;
      lock_cnt       <= next_lock_cnt;
      pll_lock       <= next_pll_lock;
      pdiv_cnt       <= next_pdiv_cnt;
      pclk_en_out    <= next_pclk_en;
      cpu_clk_en_out <= next_cpu_en;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    unique case (paddr_in)
      scpc_pkg::OFS_PLL_CTRL: begin
        rd_val[scpc_pkg::PLL_EN_BIT]   = pll_en;
        rd_val[scpc_pkg::PLL_CONN_BIT] = pll_conn;
      end
      scpc_pkg::OFS_PLL_CFG: begin
        rd_val[scpc_pkg::CFG_MSEL_LSB +: scpc_pkg::MSEL_W] = msel;
        rd_val[scpc_pkg::CFG_PSEL_LSB +: scpc_pkg::PSEL_W] = psel;
      end
      scpc_pkg::OFS_PLL_STAT: begin
        rd_val[scpc_pkg::STAT_LOCK_BIT] = pll_lock;
        rd_val[scpc_pkg::STAT_RUN_BIT]  = pll_run;
        rd_val[scpc_pkg::STAT_CONN_BIT] = use_pll;
      end
      scpc_pkg::OFS_PWR_MODE: begin
        rd_val[scpc_pkg::PWR_IDLE_BIT] = (st == scpc_pkg::ST_IDLE);
        rd_val[scpc_pkg::PWR_PD_BIT]   = (st == scpc_pkg::ST_PDOWN);
      end
      scpc_pkg::OFS_PERIPH:   rd_val[NPERIPH-1:0] = pper;
      scpc_pkg::OFS_PCLK_DIV: rd_val[1:0] = pdiv;
      scpc_pkg::OFS_MEM_MAP:  rd_val[0] = remap;
      scpc_pkg::OFS_EXT_WAKE: rd_val[2:0] = wake_en;
      scpc_pkg::OFS_RST_STAT: rd_val[1:0] = rst_stat;
      default:                hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st        = st;
    next_pll_en    = pll_en;
    next_pll_conn  = pll_conn;
    next_msel      = msel;
    next_psel      = psel;
    next_pdiv      = pdiv;
    next_remap     = remap;
    next_wake_en   = wake_en;
    next_pper      = pper;
    next_from_rst  = from_rst;
    next_wake_cnt  = wake_cnt;
    next_chip_rst  = chip_rst_out;
    next_cpu_start = 1'b0;
    next_pready    = apb_rd_phase;
    next_prdata    = apb_rd_phase ? rd_val : prdata_out;
    next_pslverr   = apb_rd_phase ? ~hit : pslverr_out;
    // Write-one-to-clear; a new event in the same cycle wins
    next_rst_stat = rst_stat;
    if (apb_wr && paddr_in == scpc_pkg::OFS_RST_STAT) begin
      next_rst_stat = rst_stat & ~pwdata_in[1:0];
    end
    next_rst_stat[scpc_pkg::RST_PIN_BIT] =
      next_rst_stat[scpc_pkg::RST_PIN_BIT] | pin_rst;
    next_rst_stat[scpc_pkg::RST_WDT_BIT] =
      next_rst_stat[scpc_pkg::RST_WDT_BIT] | wdt_rst_in;
    if (apb_wr) begin
      unique case (paddr_in)
        scpc_pkg::OFS_PLL_CTRL: begin
          next_pll_en   = pwdata_in[scpc_pkg::PLL_EN_BIT];
          next_pll_conn = pwdata_in[scpc_pkg::PLL_CONN_BIT];
        end
        scpc_pkg::OFS_PLL_CFG: begin
          next_msel = pwdata_in[scpc_pkg::CFG_MSEL_LSB +: scpc_pkg::MSEL_W];
          next_psel = pwdata_in[scpc_pkg::CFG_PSEL_LSB +: scpc_pkg::PSEL_W];
        end
        scpc_pkg::OFS_PERIPH:   next_pper = pwdata_in[NPERIPH-1:0];
        scpc_pkg::OFS_PCLK_DIV: next_pdiv = pwdata_in[1:0];
        scpc_pkg::OFS_MEM_MAP:  next_remap = pwdata_in[0];
        scpc_pkg::OFS_EXT_WAKE: next_wake_en = pwdata_in[2:0];
        default: ;
      endcase
    end
    unique case (st)
      scpc_pkg::ST_HOLD: begin
        // Chip reset reloads every register here except rst_stat
        next_pll_en   = 1'b0;
        next_pll_conn = 1'b0;
        next_msel     = scpc_pkg::MSEL_RST;
        next_psel     = scpc_pkg::PSEL_RST;
        next_pdiv     = scpc_pkg::PDIV_RST;
        next_remap    = scpc_pkg::MAP_RST;
        next_wake_en  = scpc_pkg::WAKE_EN_RST;
        next_pper     = {NPERIPH{1'b1}};
        next_wake_cnt = '0;
        next_st       = scpc_pkg::ST_WAKE;
      end
      scpc_pkg::ST_WAKE: begin
        // Counting waits for a live oscillator
        if (osc_s && !wake_done) begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
        if (wake_done && flash_init_done_in) begin
          next_st        = scpc_pkg::ST_RUN;
          next_chip_rst  = 1'b0;
          next_cpu_start = from_rst;
          next_from_rst  = 1'b0;
        end
      end
      scpc_pkg::ST_RUN: begin
        if (apb_wr && paddr_in == scpc_pkg::OFS_PWR_MODE) begin
          if (pwdata_in[scpc_pkg::PWR_PD_BIT]) begin
            next_st = scpc_pkg::ST_PDOWN;
          end else if (pwdata_in[scpc_pkg::PWR_IDLE_BIT]) begin
            next_st = scpc_pkg::ST_IDLE;
          end
        end
      end
      scpc_pkg::ST_IDLE: begin
        if (irq_in) begin
          next_st = scpc_pkg::ST_RUN;
        end
      end
      scpc_pkg::ST_PDOWN: begin
        // Registers untouched; exit through wake timer
        if (|(ext_s & wake_en)) begin
          next_st       = scpc_pkg::ST_WAKE;
          next_wake_cnt = '0;
        end
      end
      default: next_st = scpc_pkg::ST_HOLD;
    endcase
    if (rst_src) begin
      next_st       = scpc_pkg::ST_HOLD;
      next_chip_rst = 1'b1;
      next_from_rst = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st             <= scpc_pkg::ST_HOLD;
      pll_en         <= 1'b0;
      pll_conn       <= 1'b0;
      msel           <= scpc_pkg::MSEL_RST;
      psel           <= scpc_pkg::PSEL_RST;
      pdiv           <= scpc_pkg::PDIV_RST;
      remap          <= scpc_pkg::MAP_RST;
      wake_en        <= scpc_pkg::WAKE_EN_RST;
      pper           <= {NPERIPH{1'b1}};
      rst_stat       <= 2'h0;
      from_rst       <= 1'b1;
      wake_cnt       <= '0;
      chip_rst_out   <= 1'b1;
      cpu_start_out  <= 1'b0;
      pready_out     <= 1'b0;
      prdata_out     <= 32'h0000_0000;
      pslverr_out    <= 1'b0;
      osc_en_out     <= 1'b1;
      pin_hold_out   <= 1'b0;
      pll_lock_out   <= 1'b0;
      remap_sram_out <= scpc_pkg::MAP_RST;
      periph_pwr_out <= {NPERIPH{1'b1}};
    end else begin
      st             <= next_st;
      pll_en         <= next_pll_en;
      pll_conn       <= next_pll_conn;
      msel           <= next_msel;
      psel           <= next_psel;
      pdiv           <= next_pdiv;
      remap          <= next_remap;
      wake_en        <= next_wake_en;
      pper           <= next_pper;
      rst_stat       <= next_rst_stat;
      from_rst       <= next_from_rst;
      wake_cnt       <= next_wake_cnt;
      chip_rst_out   <= next_chip_rst;
      cpu_start_out  <= next_cpu_start;
      pready_out     <= next_pready;
      prdata_out     <= next_prdata;
      pslverr_out    <= next_pslverr;
      osc_en_out     <= (next_st != scpc_pkg::ST_PDOWN);
      pin_hold_out   <= (next_st == scpc_pkg::ST_PDOWN);
      pll_lock_out   <= next_pll_lock;
      remap_sram_out <= next_remap;
      periph_pwr_out <= next_pper;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_rst_src;
    rst_src |=> chip_rst_out && st == scpc_pkg::ST_HOLD;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset not held");

  property p_rst_release;
    $fell(chip_rst_out) |-> $past(wake_done) && $past(flash_init_done_in)
      && cpu_start_out && !pll_en && pdiv == scpc_pkg::PDIV_DIV4;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("bad release");

  property p_pd_exit;
    (st == scpc_pkg::ST_PDOWN && next_st != scpc_pkg::ST_PDOWN)
      |=> st == scpc_pkg::ST_WAKE || st == scpc_pkg::ST_HOLD;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("pd skip wake");

  property p_ext_wake;
    (st == scpc_pkg::ST_PDOWN && |(ext_s & wake_en) && !rst_src)
      |=> st == scpc_pkg::ST_WAKE;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("no ext wake");

  property p_idle_gate;
    st == scpc_pkg::ST_IDLE |=> !cpu_clk_en_out;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle clk");

  property p_idle_pclk;
    (st == scpc_pkg::ST_IDLE && !use_pll && pdiv == scpc_pkg::PDIV_DIV1)
      |=> pclk_en_out;
  endproperty
  a_idle_pclk: assert property (p_idle_pclk) else $error("idle pclk");

  // Pin outputs are registered from next_st, so they change in the same cycle as st
  property p_pdown;
    st == scpc_pkg::ST_PDOWN |-> (!osc_en_out && pin_hold_out)
      ##1 (!cpu_clk_en_out && !pclk_en_out);
  endproperty
  a_pdown: assert property (p_pdown) else $error("pd clocks live");

  property p_osc_src;
    (st == scpc_pkg::ST_RUN && !use_pll) |=> cpu_clk_en_out;
  endproperty
  a_osc_src: assert property (p_osc_src) else $error("osc bypass");

  property p_pclk_quarter;
    (pclk_en_out && pdiv == scpc_pkg::PDIV_DIV4 && !use_pll && !psel_in
      && st == scpc_pkg::ST_RUN) |=> !pclk_en_out [*3];
  endproperty
  a_pclk_quarter: assert property (p_pclk_quarter) else $error("pdiv4");

  property p_duty;
    $changed(pll_clk_out) && $past(pll_run)
      |-> $past(pll_half) == $past(half_lim);
  endproperty
  a_duty: assert property (p_duty) else $error("pll duty");

  c_lock: cover property (pll_run ##[1:1000] pll_lock_out);
  c_pd_wake: cover property (st == scpc_pkg::ST_PDOWN
    ##1 st == scpc_pkg::ST_WAKE);
  c_idle_exit: cover property (st == scpc_pkg::ST_IDLE
    ##1 st == scpc_pkg::ST_RUN);
  c_release: cover property ($fell(chip_rst_out));
endmodule

/* File: tb/scpc_far_model.sv */
`timescale 1ns/1ns
module scpc_far_model #(
  parameter int OSC_DLY   = 3,
  parameter int FLASH_DLY = 2
) (
  input  wire logic clk_in,
  input  wire logic osc_en_in,
  output logic      osc_running_out,
  output logic      flash_done_out
);
  int osc_cnt = 0;
  int fl_cnt  = 0;
  // Crystal needs a few cycles to build amplitude after enable
  always @(posedge clk_in) begin
    if (!osc_en_in)
      osc_cnt <= 0;
    else if (osc_cnt < OSC_DLY)
      osc_cnt <= osc_cnt + 1;
    if (!osc_running_out)
      fl_cnt <= 0;
    else if (fl_cnt < FLASH_DLY)
      fl_cnt <= fl_cnt + 1;
  end
  assign osc_running_out = (osc_cnt >= OSC_DLY);
  assign flash_done_out  = (fl_cnt >= FLASH_DLY);
endmodule

/* File: tb/tb_system_clock_reset_power_control.sv */
`timescale 1ns/1ns
module tb_system_clock_reset_power_control;
  typedef struct {logic [11:0] a; logic [31:0] e;} scpc_row_s;
  logic        clk, rst, psel, pen, pwr, rpn, wdt, irq, prdy, perr, err;
  logic        oscr, fdone, osce, pllc, lock, cen, pce, crst, cst;
  logic        remap, hold, st, sr;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [2:0]  ext;
  logic [7:0]  ppwr;
  int          failures, n_tests, cc, cp, ch, n;
  scpc_row_s   rows[6] = '{'{scpc_pkg::OFS_PLL_CTRL, 32'h0},
    '{scpc_pkg::OFS_PLL_CFG, 32'h0}, '{scpc_pkg::OFS_PERIPH, 32'hFF},
    '{scpc_pkg::OFS_PCLK_DIV, 32'h0}, '{scpc_pkg::OFS_MEM_MAP, 32'h0},
    '{scpc_pkg::OFS_EXT_WAKE, 32'h0}};

  scpc_top #(.LOCK_CYCLES(20), .WAKE_CYCLES(8)) scpc_top_i (
    .sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .rst_pin_n_in(rpn),
    .wdt_rst_in(wdt), .osc_running_in(oscr), .flash_init_done_in(fdone),
    .ext_int_in(ext), .irq_in(irq), .osc_en_out(osce), .pll_clk_out(pllc),
    .pll_lock_out(lock), .cpu_clk_en_out(cen), .pclk_en_out(pce),
    .chip_rst_out(crst), .cpu_start_out(cst), .remap_sram_out(remap),
    .periph_pwr_out(ppwr), .pin_hold_out(hold));
  scpc_far_model scpc_far_model_i (.clk_in(clk), .osc_en_in(osce),
    .osc_running_out(oscr), .flash_done_out(fdone));

  task results;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  // Holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (prdy === 1'b1)
        break;
    end
    if (k == 16) begin
      failures++;
      results();
    end
    rd = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task cnt(input int c);
    cc = 0;
    cp = 0;
    ch = 0;
    repeat (c) begin
      @(negedge clk);
      cc += cen;
      cp += pce;
      ch += pllc;
    end
    @(posedge clk);
  endtask
  task waitc(input int k);
    st = 0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      st |= cst;
      sr |= crst;
      if ((k == 0 && !crst) || (k == 1 && cen) || (k == 2 && crst))
        break;
    end
    if (n == 400) begin
      failures++;
      results();
    end
    @(posedge clk);
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    {psel, pen, pwr, pa, pwd, rpn, wdt, irq, ext, sr} = '0;
    rst = 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    rpn <= 1;
    waitc(0);
    chk(st, 1);
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      chk(rd, rows[i].e);
    end
    apb(0, 12'h0FC, 32'h0);
    chk(err, 1);
    cnt(16);
    chk(cc, 16);
    chk(cp, 4);
    apb(1, scpc_pkg::OFS_PCLK_DIV, 32'h2);
    cnt(16);
    chk(cp, 8);
    apb(1, scpc_pkg::OFS_MEM_MAP, 32'h1);
    apb(1, scpc_pkg::OFS_PERIPH, 32'h0F);
    cnt(2);
    chk(remap, 1);
    chk(ppwr, 8'h0F);
    $display("test registers done");
    apb(1, scpc_pkg::OFS_PLL_CFG, 32'h3);
    apb(1, scpc_pkg::OFS_PLL_CTRL, 32'h1);
    rd = 0;
    for (int i = 0; i < 10 && rd[0] !== 1'b1; i++)
      apb(0, scpc_pkg::OFS_PLL_STAT, 0);
    chk(rd[0], 1);
    apb(1, scpc_pkg::OFS_PLL_CTRL, 32'h3);
    apb(0, scpc_pkg::OFS_PLL_STAT, 0);
    chk(rd[2:0], 3'h7);
    cnt(64);
    chk(cc, 4);
    chk(ch, 32);
    $display("test pll done");
    apb(1, scpc_pkg::OFS_PWR_MODE, 32'h1);
    cnt(32);
    chk(cc, 0);
    chk(cp != 0, 1);
    chk(lock, 1);
    irq <= 1;
    cnt(2);
    irq <= 0;
    cnt(32);
    chk(cc != 0, 1);
    $display("test idle done");
    apb(1, scpc_pkg::OFS_EXT_WAKE, 32'h1);
    apb(1, scpc_pkg::OFS_PWR_MODE, 32'h2);
    cnt(8);
    chk({osce, hold, lock}, 3'h2);
    chk(cc, 0);
    ext <= 3'h1;
    sr = 0;
    waitc(1);
    chk(n >= 8, 1);
    chk({sr, st}, 0);
    ext <= 3'h0;
    apb(0, scpc_pkg::OFS_PERIPH, 0);
    chk(rd, 32'h0F);
    apb(0, scpc_pkg::OFS_MEM_MAP, 0);
    chk(rd, 32'h1);
    $display("test power-down done");
    wdt <= 1;
    waitc(2);
    wdt <= 0;
    waitc(0);
    chk(st, 1);
    apb(0, scpc_pkg::OFS_RST_STAT, 0);
    chk(rd[1], 1);
    apb(0, scpc_pkg::OFS_MEM_MAP, 0);
    chk(rd, 32'h0);
    $display("test watchdog done");
    apb(1, scpc_pkg::OFS_PCLK_DIV, 32'h1);
    apb(1, scpc_pkg::OFS_PWR_MODE, 32'h1);
    cnt(8);
    chk(cp, 8);
    chk(cc, 0);
    irq <= 1;
    cnt(2);
    irq <= 0;
    $display("test idle full rate done");
    apb(1, scpc_pkg::OFS_PLL_CFG, 32'h23);
    apb(1, scpc_pkg::OFS_PLL_CTRL, 32'h1);
    repeat (8)
      apb(0, scpc_pkg::OFS_PLL_STAT, 0);
    chk(rd[2:0], 3'h3);
    apb(1, scpc_pkg::OFS_PLL_CTRL, 32'h3);
    cnt(64);
    chk(cc, 2);
    chk(ch, 32);
    $display("test divider done");
    results();
  end
endmodule
